// File: rtl/core_decode_pkg.sv
// constants for the transport-triggered core decode, stack and lock logic
package core_decode_pkg;
    localparam int INSTR_W = 16;
    localparam int FMT_BIT = 15;
    localparam int SRC_LSB = 0;
    localparam int SRC_MSB = 7;
    localparam int DST_LSB = 8;
    localparam int DST_MSB = 14;
    localparam int MOD_W = 4;
    localparam int DST_SUB_W = 3;
    localparam int PFX_W = 2;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 4;
    localparam logic [3:0] SP_RESET = 4'hF;
    localparam logic [15:0] UROM_BASE = 16'h8000;
    localparam int UROM_WORDS = 2048;
    localparam logic [15:0] USER_START = 16'h0000;
    localparam logic [15:0] PW_FIRST = 16'h0010;
    localparam logic [15:0] PW_LAST = 16'h001F;
    localparam logic [15:0] WORD_ONES = 16'hFFFF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    // system module (module 8) and accumulator module (module 9) register subindices used by the core
    localparam logic [3:0] MOD_SYS = 4'h8;
    localparam logic [3:0] MOD_ACC = 4'h9;
    localparam logic [4:0] REG_PFX = 5'h00;
    localparam logic [4:0] REG_SP = 5'h01;
    localparam logic [4:0] REG_STK = 5'h02;
    localparam logic [4:0] REG_CALL = 5'h03;
    localparam logic [4:0] REG_RET = 5'h04;
    localparam logic [4:0] REG_RETURN_FROM_INTERRUPT_OP = 5'h05;
    localparam logic [4:0] REG_POP_RESTORE_INTERRUPT_OP = 5'h06;
    localparam logic [4:0] REG_JUMP = 5'h07;
    localparam logic [4:0] REG_SC = 5'h08;
    localparam logic [4:0] REG_DP0 = 5'h0C;
    localparam logic [4:0] REG_ACC = 5'h00;
    localparam logic [4:0] REG_ADD = 5'h01;
    localparam logic [4:0] REG_AND = 5'h02;
    localparam logic [4:0] REG_OR = 5'h03;
    localparam logic [4:0] REG_XOR = 5'h04;
    localparam logic [4:0] REG_DPCTL = 5'h05;
    localparam int NUM_DP = 3;
    // system control bits
    localparam int SC_PWL = 1;
    localparam int SC_SPE = 0;
    localparam int SC_UNIFIED = 2;
    // bootstrap loader command codes
    typedef enum logic [2:0] {
        BL_NONE = 3'h0,
        BL_LOAD = 3'h1,
        BL_VERIFY = 3'h2,
        BL_DUMP = 3'h3,
        BL_ERASE = 3'h4,
        BL_CRC = 3'h5
    } bl_cmd_t;
endpackage : core_decode_pkg

// File: rtl/risc_core_decode_stack_lock.sv
// single-cycle transport-triggered core: decode, stack, pointers and lock
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - every instruction is one 16-bit move
// - bit 15 selects immediate or register source
// - bits 7..0 carry the source operand
// - source low nibble module, high nibble index
// - bits 14..8 name destination module, subindex
// - prefix write extends destination, one extra cycle
// - special register moves trigger alu, jumps
// - fetch and execute in one cycle
// - three data pointers with automatic stepping
// - 16-bit stack used by call, return, interrupt
// - stack pointer resets to 0Fh
// - push: increment pointer, then write
// - pop: read entry, then decrement pointer
// - 4KB utility rom based at 8000h
// - every reset starts execution in utility rom
// - password is program words 0010h..001Fh
// - lock set at power-on; gates debug access
// - cleared lock gives access without password
// - mass erase sets password words to ones
// - program-enable bit at reset selects loader
// - loader offers load, verify, dump, erase, crc
// - harvard map by default, unified optional
module risc_core_decode_stack_lock #(
    parameter int DATA_W = 16,
    parameter int STACK_DEPTH = core_decode_pkg::STACK_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic por_event,
    input wire logic [15:0] instr,
    input wire logic [15:0] src_rd_data,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [15:0] dmem_rd_data,
    input wire logic pw_all_ones,
    input wire logic pw_all_zero,
    input wire logic pw_matched,
    input wire logic spe_host_set,
    input wire logic spe_host_value,
    input wire logic mass_erase_done,
    input wire logic [2:0] bl_cmd_in,
    output logic [15:0] prog_addr,
    output logic [7:0] src_sel,
    output logic src_rd,
    output logic [6:0] dst_sel,
    output logic [1:0] dst_prefix,
    output logic dst_wr,
    output logic [15:0] dst_wr_data,
    output logic [15:0] dmem_addr,
    output logic dmem_rd,
    output logic [15:0] pw_scan_addr,
    output logic debug_access_ok,
    output logic [2:0] bl_cmd_active,
    output logic pw_erase_fill,
    output logic unified_map,
    output logic [3:0] stack_pointer_out,
    output logic [15:0] accum_out
);
    localparam int SP_W = core_decode_pkg::SP_W;
    localparam logic [2:0] SC_POR_VALUE = 3'(1 << core_decode_pkg::SC_PWL);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DATA_W != core_decode_pkg::INSTR_W)
        $error("data width must equal the 16-bit instruction word");
    if (STACK_DEPTH != (1 << SP_W))
        $error("stack depth must match the 4-bit stack pointer");
    if (core_decode_pkg::SP_RESET != 4'(STACK_DEPTH - 1))
        $error("stack pointer must reset to the top entry");

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic fmt_reg_src;
    logic [7:0] src_field;
    logic [3:0] src_mod;
    logic [3:0] src_idx;
    logic [3:0] dst_mod;
    logic [2:0] dst_sub;
    logic [4:0] dst_full;
    logic [15:0] src_value;
    assign fmt_reg_src = instr[core_decode_pkg::FMT_BIT];
    assign src_field = instr[core_decode_pkg::SRC_MSB:core_decode_pkg::SRC_LSB];
    assign src_mod = src_field[3:0];
    assign src_idx = src_field[7:4];
    assign dst_mod = instr[core_decode_pkg::DST_LSB+3:core_decode_pkg::DST_LSB];
    assign dst_sub = instr[core_decode_pkg::DST_MSB:core_decode_pkg::DST_LSB+4];

    logic [1:0] destination_prefix_reg;
    logic [1:0] destination_prefix_next;
    assign dst_full = {destination_prefix_reg, dst_sub};
    assign src_value = fmt_reg_src ? src_rd_data : {8'h00, src_field};

    // ------------------------------------------------------------
    // core state
    // ------------------------------------------------------------
    logic [15:0] pc_reg;
    logic [15:0] acc_reg;
    logic [3:0] stack_pointer;
    logic [15:0] stack_mem [STACK_DEPTH];
    logic [15:0] dp_reg [core_decode_pkg::NUM_DP];
    logic [1:0] dp_step_reg [core_decode_pkg::NUM_DP];
    logic [2:0] system_control_reg;
    logic sys_dst;
    logic acc_dst;
    logic do_push;
    logic do_pop;
    logic do_jump;
    logic irq_take;
    logic [15:0] push_value;
    logic [15:0] pc_next;
    logic [3:0] sp_inc;
    logic [15:0] stack_top;
    logic [3:0] sp_next;
    logic [15:0] acc_next;

    assign sys_dst = dst_mod == core_decode_pkg::MOD_SYS;
    assign acc_dst = dst_mod == core_decode_pkg::MOD_ACC;
    // an interrupt discards the fetched word: only the vector, the push and any data pointer step happen
    assign irq_take = irq_req;
    assign sp_inc = stack_pointer + 4'h1;
    assign stack_top = stack_mem[stack_pointer];
    // push family: explicit push, call, interrupt vectoring
    assign do_push = irq_take || (sys_dst && (dst_full == core_decode_pkg::REG_STK
        || dst_full == core_decode_pkg::REG_CALL));
    // pop family: return, return from interrupt, pop-restore
    assign do_pop = !irq_take && sys_dst && (dst_full == core_decode_pkg::REG_RET
        || dst_full == core_decode_pkg::REG_RETURN_FROM_INTERRUPT_OP || dst_full == core_decode_pkg::REG_POP_RESTORE_INTERRUPT_OP);
    assign do_jump = !irq_take && sys_dst && (dst_full == core_decode_pkg::REG_JUMP
        || dst_full == core_decode_pkg::REG_CALL);
    assign push_value = irq_take ? pc_reg
        : (dst_full == core_decode_pkg::REG_CALL ? pc_reg + 16'h0001 : src_value);

    always_comb
    begin
        pc_next = pc_reg + 16'h0001;
        if (irq_take)
            pc_next = irq_vector;
        else if (do_jump)
            pc_next = src_value;
        else if (do_pop && dst_full != core_decode_pkg::REG_POP_RESTORE_INTERRUPT_OP)
            pc_next = stack_top;
    end

    always_comb
    begin
        destination_prefix_next = 2'h0;
        // a prefix is spent by the very next instruction
        if (!irq_take && sys_dst && dst_full == core_decode_pkg::REG_PFX)
            destination_prefix_next = src_value[1:0];
    end

    // ------------------------------------------------------------
    // program counter and reset entry
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            pc_reg <= core_decode_pkg::UROM_BASE;
        else if (clk_en)
            pc_reg <= pc_next;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            destination_prefix_reg <= 2'h0;
        else if (clk_en)
            destination_prefix_reg <= destination_prefix_next;
    end

    // ------------------------------------------------------------
    // stack
    // ------------------------------------------------------------
    // the output copy takes the same next value, so it never lags the stack
    always_comb
    begin
        sp_next = stack_pointer;
        if (do_push)
            sp_next = sp_inc;
        else if (do_pop)
            sp_next = stack_pointer - 4'h1;
        else if (!irq_take && sys_dst && dst_full == core_decode_pkg::REG_SP)
            sp_next = src_value[3:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            stack_pointer <= core_decode_pkg::SP_RESET;
        else if (clk_en)
            stack_pointer <= sp_next;
    end

    always_ff @(posedge ref_clk)
    begin
        if (clk_en && do_push)
            stack_mem[sp_inc] <= push_value;
    end

    // ------------------------------------------------------------
    // accumulator and alu side effects
    // ------------------------------------------------------------
    always_comb
    begin
        acc_next = acc_reg;
        if (!irq_take && acc_dst)
        begin
            case (dst_full)
                core_decode_pkg::REG_ACC: acc_next = src_value;
                core_decode_pkg::REG_ADD: acc_next = acc_reg + src_value;
                core_decode_pkg::REG_AND: acc_next = acc_reg & src_value;
                core_decode_pkg::REG_OR: acc_next = acc_reg | src_value;
                core_decode_pkg::REG_XOR: acc_next = acc_reg ^ src_value;
                default: acc_next = acc_reg;
            endcase
        end
        else if (!irq_take && do_pop && dst_full == core_decode_pkg::REG_POP_RESTORE_INTERRUPT_OP)
            acc_next = stack_top;
    end

    // ------------------------------------------------------------
    // accumulator register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            acc_reg <= 16'h0000;
        else if (clk_en)
            acc_reg <= acc_next;
    end

    // ------------------------------------------------------------
    // data pointers: step after each access through them when their step setting is 1 (up) or 2 (down)
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < core_decode_pkg::NUM_DP; g++)
        begin : g_dp
            logic load_hit;
            logic access_hit;
            assign load_hit = !irq_take && sys_dst
                && dst_full == core_decode_pkg::REG_DP0 + 5'(g);
            assign access_hit = fmt_reg_src && src_mod == core_decode_pkg::MOD_SYS
                && {1'b0, src_idx} == core_decode_pkg::REG_DP0 + 5'(g);
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                begin
                    dp_reg[g] <= 16'h0000;
                    dp_step_reg[g] <= 2'h0;
                end
                else if (clk_en)
                begin
                    if (load_hit)
                        dp_reg[g] <= src_value;
                    else if (access_hit && dp_step_reg[g] == 2'h1)
                        dp_reg[g] <= dp_reg[g] + 16'h0001;
                    else if (access_hit && dp_step_reg[g] == 2'h2)
                        dp_reg[g] <= dp_reg[g] - 16'h0001;
                    if (!irq_take && acc_dst && dst_full == core_decode_pkg::REG_DPCTL)
                        dp_step_reg[g] <= src_value[2*g+1 -: 2];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // system control, lock and loader entry
    // ------------------------------------------------------------
    logic pw_blank;
    logic loader_mode;
    assign pw_blank = pw_all_ones || pw_all_zero;
    assign loader_mode = system_control_reg[core_decode_pkg::SC_SPE];

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            if (por_event)
                system_control_reg <= SC_POR_VALUE;
            else
                system_control_reg[core_decode_pkg::SC_UNIFIED] <= 1'b0;
            // the host sets or clears program enable while reset is held
            if (spe_host_set)
                system_control_reg[core_decode_pkg::SC_SPE] <= spe_host_value;
        end
        else if (clk_en)
        begin
            if (spe_host_set)
                system_control_reg[core_decode_pkg::SC_SPE] <= spe_host_value;
            else if (!irq_take && sys_dst && dst_full == core_decode_pkg::REG_SC)
                system_control_reg <= src_value[2:0];
            if (pw_matched)
                system_control_reg[core_decode_pkg::SC_PWL] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            debug_access_ok <= 1'b0;
            bl_cmd_active <= 3'h0;
            pw_erase_fill <= 1'b0;
            pw_scan_addr <= core_decode_pkg::PW_FIRST;
        end
        else if (clk_en)
        begin
            debug_access_ok <= !system_control_reg[core_decode_pkg::SC_PWL] || pw_blank;
            if (loader_mode && (debug_access_ok || bl_cmd_in == core_decode_pkg::BL_ERASE)
                && bl_cmd_in <= core_decode_pkg::BL_CRC)
                bl_cmd_active <= bl_cmd_in;
            else
                bl_cmd_active <= core_decode_pkg::BL_NONE;
            pw_erase_fill <= mass_erase_done;
            if (pw_scan_addr == core_decode_pkg::PW_LAST)
                pw_scan_addr <= core_decode_pkg::PW_FIRST;
            else
                pw_scan_addr <= pw_scan_addr + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prog_addr <= core_decode_pkg::UROM_BASE;
            src_sel <= 8'h00;
            src_rd <= 1'b0;
            dst_sel <= 7'h00;
            dst_prefix <= 2'h0;
            dst_wr <= 1'b0;
            dst_wr_data <= 16'h0000;
            dmem_addr <= 16'h0000;
            dmem_rd <= 1'b0;
            unified_map <= 1'b0;
            stack_pointer_out <= core_decode_pkg::SP_RESET;
            accum_out <= 16'h0000;
        end
        else if (clk_en)
        begin
            prog_addr <= pc_next;
            src_sel <= src_field;
            src_rd <= fmt_reg_src;
            dst_sel <= instr[core_decode_pkg::DST_MSB:core_decode_pkg::DST_LSB];
            dst_prefix <= destination_prefix_reg;
            dst_wr <= !irq_take && !sys_dst && !acc_dst;
            dst_wr_data <= src_value;
            dmem_addr <= dp_reg[0];
            dmem_rd <= fmt_reg_src && src_mod == core_decode_pkg::MOD_SYS
                && {1'b0, src_idx} == core_decode_pkg::REG_DP0;
            unified_map <= system_control_reg[core_decode_pkg::SC_UNIFIED];
            // state copies take next values so they agree with the state itself
            stack_pointer_out <= sp_next;
            accum_out <= acc_next;
        end
    end
endmodule : risc_core_decode_stack_lock
`default_nettype wire

// File: tb/core_checker_properties.sv
// assertion checker for the core decode, stack and lock block
`timescale 1ns/1ps
`default_nettype none
module core_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [15:0] instr,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic pw_matched,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] src_sel,
    input wire logic src_rd,
    input wire logic [6:0] dst_sel,
    input wire logic dst_wr,
    input wire logic [15:0] dst_wr_data,
    input wire logic debug_access_ok,
    input wire logic [3:0] stack_pointer_out
);
    // a pending prefix changes the meaning of the next destination
    logic pfx_reg;
    wire logic go = rst_n && clk_en && !irq_req && !pfx_reg;
    wire logic per = go && instr[11:8] != 4'h8 && instr[11:8] != 4'h9;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            pfx_reg <= 1'b0;
        else if (clk_en)
            pfx_reg <= go && instr[14:8] == 7'h08;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    reset_pc_a: assert property (disable iff (1'b0) !rst_n |=> prog_addr == 16'h8000)
        else $error("pc not at rom base");
    reset_sp_a: assert property (disable iff (1'b0) !rst_n |=> stack_pointer_out == 4'hF)
        else $error("sp not at top");
    push_inc_a: assert property (go && instr[14:8] == 7'h28 |=> stack_pointer_out == $past(stack_pointer_out) + 4'h1)
        else $error("push step wrong");
    pop_dec_a: assert property (go && instr[14:8] == 7'h48 |=> stack_pointer_out == $past(stack_pointer_out) - 4'h1)
        else $error("pop step wrong");
    seq_pc_a: assert property (go && instr[11:8] != 4'h8 |=> prog_addr == $past(prog_addr) + 16'h0001)
        else $error("pc did not advance");
    freeze_state_a: assert property (!clk_en |=> $stable(prog_addr) && $stable(stack_pointer_out))
        else $error("state moved while frozen");
    src_field_a: assert property (go |=> src_sel == $past(instr[7:0]) && src_rd == $past(instr[15]))
        else $error("source field wrong");
    dst_write_a: assert property (per |=> dst_wr && dst_sel == $past(instr[14:8]))
        else $error("destination write wrong");
    imm_data_a: assert property (per && !instr[15] |=> dst_wr_data == {8'h00, $past(instr[7:0])})
        else $error("immediate data wrong");
    irq_vec_a: assert property (clk_en && irq_req |=> prog_addr == $past(irq_vector) ##0 stack_pointer_out == $past(stack_pointer_out) + 4'h1)
        else $error("vectoring wrong");
    unlock_seen_a: assert property (clk_en && pw_matched |-> ##[1:2] debug_access_ok)
        else $error("lock not cleared");
    cover property (go && instr[14:8] == 7'h28);
    cover property (go && instr[14:8] == 7'h48);
    cover property (clk_en && irq_req);
endmodule : core_checker
bind risc_core_decode_stack_lock core_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .instr(instr), .irq_req(irq_req), .irq_vector(irq_vector), .pw_matched(pw_matched),
    .prog_addr(prog_addr), .src_sel(src_sel), .src_rd(src_rd), .dst_sel(dst_sel), .dst_wr(dst_wr),
    .dst_wr_data(dst_wr_data), .debug_access_ok(debug_access_ok), .stack_pointer_out(stack_pointer_out));
`default_nettype wire

// File: tb/periph_regs_model.sv
// peripheral register model answering source reads and taking writes
`timescale 1ns/1ps
`default_nettype none
module periph_regs_model (
    input wire logic ref_clk,
    input wire logic [15:0] instr,
    input wire logic dst_wr,
    input wire logic [6:0] dst_sel,
    input wire logic [15:0] dst_wr_data,
    output logic [15:0] src_rd_data
);
    logic [15:0] mem [256];
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = {i[7:0], 8'h5A};
    end
    // inverted pattern when the source is not a register read
    assign src_rd_data = instr[15] ? mem[instr[7:0]] : ~mem[instr[7:0]];
    always @(posedge ref_clk)
        if (dst_wr)
            mem[{1'b0, dst_sel}] <= dst_wr_data;
endmodule : periph_regs_model
`default_nettype wire

// File: tb/tb_risc_core_decode_stack_lock.sv
// self-checking testbench for the core decode, stack and lock block
`timescale 1ns/1ps
`default_nettype none
module tb_risc_core_decode_stack_lock;
    localparam logic [15:0] nop_instr = 16'h0100;
    logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b0, por_event = 1'b1, irq_req = 1'b0;
    logic pw_all_ones = 1'b0, pw_all_zero = 1'b0, pw_matched = 1'b0, mass_erase_done = 1'b0;
    logic spe_host_set = 1'b0, spe_host_value = 1'b0;
    logic [15:0] instr = 16'h0100, irq_vector = 16'h0000, src_rd_data;
    logic [2:0] bl_cmd_in = 3'h0, bl_cmd_active;
    logic [15:0] prog_addr, dst_wr_data, dmem_addr, pw_scan_addr, accum_out;
    logic [7:0] src_sel;
    logic [6:0] dst_sel;
    logic [1:0] dst_prefix;
    logic [3:0] stack_pointer_out;
    logic src_rd, dst_wr, dmem_rd, debug_access_ok, pw_erase_fill, unified_map;
    int fail_count = 0, checked = 0;
    always #10 ref_clk = ~ref_clk;
    risc_core_decode_stack_lock dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .por_event(por_event),
        .instr(instr), .src_rd_data(src_rd_data), .irq_req(irq_req), .irq_vector(irq_vector),
        .dmem_rd_data(16'h0000), .pw_all_ones(pw_all_ones), .pw_all_zero(pw_all_zero),
        .pw_matched(pw_matched), .spe_host_set(spe_host_set), .spe_host_value(spe_host_value),
        .mass_erase_done(mass_erase_done), .bl_cmd_in(bl_cmd_in), .prog_addr(prog_addr), .src_sel(src_sel),
        .src_rd(src_rd), .dst_sel(dst_sel), .dst_prefix(dst_prefix), .dst_wr(dst_wr), .dst_wr_data(dst_wr_data),
        .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .pw_scan_addr(pw_scan_addr), .debug_access_ok(debug_access_ok),
        .bl_cmd_active(bl_cmd_active), .pw_erase_fill(pw_erase_fill), .unified_map(unified_map),
        .stack_pointer_out(stack_pointer_out), .accum_out(accum_out));
    periph_regs_model far_i (.ref_clk(ref_clk), .instr(instr), .dst_wr(dst_wr), .dst_sel(dst_sel),
        .dst_wr_data(dst_wr_data), .src_rd_data(src_rd_data));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic ex(input logic [15:0] v);
        clk_en <= 1'b1;
        instr <= v;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : ex
    task automatic ex2;
        ex(nop_instr);
        ex(nop_instr);
    endtask : ex2
    task automatic rst(input logic por, input logic system_program_enable_bit, input int n);
        rst_n <= 1'b0;
        clk_en <= 1'b1;
        por_event <= por;
        spe_host_set <= 1'b1;
        spe_host_value <= system_program_enable_bit;
        repeat (n) @(negedge ref_clk);
        rst_n <= 1'b1;
        clk_en <= 1'b0;
        por_event <= 1'b0;
        spe_host_set <= 1'b0;
        @(negedge ref_clk);
        chk("pc", prog_addr, 16'h8000);
        chk("sp", stack_pointer_out, 16'h000F);
        chk("scan", pw_scan_addr, 16'h0010);
    endtask : rst
    task automatic t_moves;
        logic [15:0] pc;
        pc = prog_addr;
        chk("map", unified_map, 16'h0000);
        ex(16'h315A);
        chk("dst", dst_sel, 16'h0031);
        chk("imm", dst_wr_data, 16'h005A);
        ex(16'h8142);
        chk("src", src_sel, 16'h0042);
        chk("reg", dst_wr_data, 16'h425A);
        chk("pc", prog_addr, pc + 16'h0002);
        $display("test moves done");
    endtask : t_moves
    task automatic t_acc;
        logic [15:0] op [5] = '{16'h090C, 16'h1903, 16'h290A, 16'h3950, 16'h49FF};
        logic [15:0] res [5] = '{16'h000C, 16'h000F, 16'h000A, 16'h005A, 16'h00A5};
        for (int i = 0; i < 5; i++)
        begin
            ex(op[i]);
            chk("acc", accum_out, res[i]);
        end
        $display("test alu done");
    endtask : t_acc
    task automatic t_stack;
        for (int i = 0; i < 16; i++)
        begin
            ex({8'h28, 4'h1, i[3:0]});
            chk("sp", stack_pointer_out, {12'h000, i[3:0]});
        end
        for (int i = 0; i < 16; i++)
        begin
            ex(16'h4800);
            chk("ret", prog_addr, {12'h001, 4'hF - i[3:0]});
            chk("sp", stack_pointer_out, {12'h000, 4'hE - i[3:0]});
        end
        irq_vector <= 16'h0123;
        irq_req <= 1'b1;
        ex(nop_instr);
        irq_req <= 1'b0;
        chk("vec", prog_addr, 16'h0123);
        ex(16'h5800);
        chk("sp", stack_pointer_out, 16'h000F);
        $display("test stack done");
    endtask : t_stack
    task automatic t_lock;
        logic seen;
        bl_cmd_in <= 3'h1;
        ex2;
        chk("dbg", debug_access_ok, 16'h0000);
        chk("bl", bl_cmd_active, 16'h0000);
        bl_cmd_in <= 3'h4;
        ex2;
        chk("bl", bl_cmd_active, 16'h0000);
        pw_all_ones <= 1'b1;
        ex2;
        chk("dbg", debug_access_ok, 16'h0001);
        pw_all_ones <= 1'b0;
        pw_all_zero <= 1'b1;
        ex2;
        chk("dbg", debug_access_ok, 16'h0001);
        pw_all_zero <= 1'b0;
        ex2;
        chk("dbg", debug_access_ok, 16'h0000);
        pw_matched <= 1'b1;
        ex(nop_instr);
        pw_matched <= 1'b0;
        ex(nop_instr);
        chk("dbg", debug_access_ok, 16'h0001);
        mass_erase_done <= 1'b1;
        ex(nop_instr);
        mass_erase_done <= 1'b0;
        seen = pw_erase_fill;
        ex(nop_instr);
        chk("fill", seen, 16'h0001);
        chk("fill", pw_erase_fill, 16'h0000);
        rst(1'b0, 1'b1, 2);
        for (int c = 1; c < 6; c++)
        begin
            bl_cmd_in <= c[2:0];
            ex2;
            chk("bl", bl_cmd_active, {13'h0000, c[2:0]});
        end
        // lock set again by software: only erase is still taken
        ex(16'h0801);
        ex(16'h0803);
        bl_cmd_in <= 3'h1;
        ex2;
        chk("bl", bl_cmd_active, 16'h0000);
        bl_cmd_in <= 3'h4;
        ex2;
        chk("bl", bl_cmd_active, 16'h0004);
        chk("dbg", debug_access_ok, 16'h0000);
        rst(1'b0, 1'b0, 2);
        bl_cmd_in <= 3'h1;
        ex2;
        chk("bl", bl_cmd_active, 16'h0000);
        bl_cmd_in <= 3'h0;
        $display("test lock done");
    endtask : t_lock
    task automatic t_prefix;
        logic [15:0] pc;
        pc = prog_addr;
        ex(16'h0801);
        ex(16'h2177);
        chk("pfx", dst_prefix, 16'h0001);
        chk("dst", dst_sel, 16'h0021);
        chk("pc", prog_addr, pc + 16'h0002);
        ex(nop_instr);
        chk("pfx", dst_prefix, 16'h0000);
        ex(16'h0801);
        ex(16'h0804);
        chk("wr", dst_wr, 16'h0000);
        ex(nop_instr);
        chk("map", unified_map, 16'h0001);
        $display("test prefix done");
    endtask : t_prefix
    task automatic t_dp;
        ex(16'h0801);
        ex(16'h4830);
        ex(16'h5901);
        ex(16'h81C8);
        chk("dmem", dmem_addr, 16'h0030);
        chk("dmrd", dmem_rd, 16'h0001);
        ex(nop_instr);
        chk("dmem", dmem_addr, 16'h0031);
        chk("dmrd", dmem_rd, 16'h0000);
        $display("test pointers done");
    endtask : t_dp
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        stop_test;
    end
    initial
    begin
        @(negedge ref_clk);
        rst(1'b1, 1'b0, 5);
        t_moves;
        t_acc;
        t_stack;
        t_lock;
        t_prefix;
        t_dp;
        stop_test;
    end
endmodule : tb_risc_core_decode_stack_lock
`default_nettype wire
